/* File: hw/fsc_pkg.sv */
package fsc_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TUNING = 8'h08;
	localparam logic [7:0] OFS_FLAG = 8'h0c;
	localparam logic [7:0] OFS_ENABLE = 8'h10;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CTL_PLL_BIT = 7;
	localparam int CTL_FREQ_LSB = 3;
	localparam logic [3:0] FREQ_RESET = 4'h7;
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam logic [2:0] FOSC_INTERNAL_OSCILLATOR = 3'h4;
	localparam logic [2:0] FOSC_CRYSTAL_LIMIT = 3'h3;
	localparam logic [3:0] FREQ_PLL_CODE = 4'he;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Counts
	// ------------------------------------------------------------
	localparam int OST_CYCLES = 1024;
	localparam int SAMPLE_DIV = 64;
	localparam int HALF_DIV = SAMPLE_DIV / 2;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_SOSC, SRC_INT} fsc_src_t;
	typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} fsc_sw_t;
	typedef enum logic [1:0] {OSC_LF, OSC_MF, OSC_HF} fsc_osc_t;
endpackage

/* File: hw/fsc_clock_select.sv */
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module fsc_clock_select #(
	parameter int OST_COUNT = fsc_pkg::OST_CYCLES,
	parameter int HALF_COUNT = fsc_pkg::HALF_DIV
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_ext_clk,
	input wire logic i_sosc_clk,
	input wire logic i_int_clk,
	input wire logic i_lf_clk,
	input wire logic [2:0] i_cfg_fosc,
	input wire logic i_config_failure_monitor_enable,
	input wire logic i_config_two_speed_enable,
	input wire logic i_config_pll_enable,
	input wire logic i_sleep,
	input wire logic i_secondary_osc_enable,
	input wire logic i_secondary_osc_ready,
	input wire logic i_pll_ready,
	input wire logic i_high_int_osc_ready,
	input wire logic i_high_int_osc_locked,
	input wire logic i_high_int_osc_stable,
	input wire logic i_medium_int_osc_ready,
	input wire logic i_low_int_osc_ready,
	output logic o_sysclk,
	output logic [1:0] o_sysclk_src,
	output logic o_switching,
	output logic [3:0] o_internal_freq_select,
	output logic [1:0] o_int_osc_kind,
	output logic o_int_freq_pll,
	output logic o_pll_on,
	output logic [5:0] o_frequency_trim,
	output logic o_osc_fail_irq
);
	if (OST_COUNT < 2 || OST_COUNT > 2047 || HALF_COUNT < 1 || HALF_COUNT > 32) begin
		$error("fsc_clock_select: count parameter out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdat;
		logic wlane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic soft_pll;
		logic [3:0] freq;
		logic [1:0] scs;
		logic [5:0] trim;
		logic flag;
		logic flag_en;
		logic irq;
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [3:0] prev_lvl;
		logic prev_sleep;
		logic [10:0] ost_cnt;
		logic ost_done;
		logic [4:0] div_cnt;
		logic sample;
		logic latch;
		logic failsafe;
		fsc_pkg::fsc_src_t cur;
		fsc_pkg::fsc_src_t sw_tgt;
		fsc_pkg::fsc_sw_t sw;
		logic sysclk;
		logic switching;
		fsc_pkg::fsc_osc_t kind;
		logic pll_x4;
		logic pll_on;
	} fsc_state_t;

	fsc_state_t st_ff;
	fsc_state_t nxt_st;

	function automatic fsc_pkg::fsc_osc_t fsc_decode(input logic [3:0] code);
		if (code[3:1] == 3'h0) begin
			fsc_decode = fsc_pkg::OSC_LF;
		end else if (code[3] == 1'b0 && code != 4'h3) begin
			fsc_decode = fsc_pkg::OSC_MF;
		end else begin
			fsc_decode = fsc_pkg::OSC_HF;
		end
	endfunction

	function automatic logic fsc_pick(input fsc_pkg::fsc_src_t s, input logic [3:0] v, input logic none_val);
		unique case (s)
			fsc_pkg::SRC_NONE: fsc_pick = none_val;
			fsc_pkg::SRC_EXT: fsc_pick = v[0];
			fsc_pkg::SRC_SOSC: fsc_pick = v[1];
			fsc_pkg::SRC_INT: fsc_pick = v[2];
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic [3:0] lvl, fall, rise;
	logic crystal, two_speed, scs_change, sleep_enter, wake, armed, fail, do_write, flag_clear, rd_hit;
	logic [7:0] rd_byte;
	fsc_pkg::fsc_src_t target;

	always_comb begin
		nxt_st = st_ff;
		lvl = {i_lf_clk, i_int_clk, i_sosc_clk, i_ext_clk};
		fall = st_ff.prev_lvl & ~lvl;
		rise = ~st_ff.prev_lvl & lvl;
		nxt_st.prev_lvl = lvl;
		crystal = i_cfg_fosc < fsc_pkg::FOSC_CRYSTAL_LIMIT;
		two_speed = i_config_two_speed_enable | i_config_failure_monitor_enable;
		sleep_enter = i_sleep & ~st_ff.prev_sleep;
		wake = ~i_sleep & st_ff.prev_sleep;
		nxt_st.prev_sleep = i_sleep;
		nxt_st.sync1 = {i_secondary_osc_ready, i_pll_ready, i_high_int_osc_ready, i_high_int_osc_locked,
			i_medium_int_osc_ready, i_low_int_osc_ready, i_high_int_osc_stable};
		nxt_st.sync2 = st_ff.sync1;

		// Write channel: address and data taken in either order
		if (i_awvalid && st_ff.awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.waddr = i_awaddr;
		end
		if (i_wvalid && st_ff.wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdat = i_wdata[7:0];
			nxt_st.wlane = i_wstrb[0];
		end
		do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
		scs_change = 1'b0;
		flag_clear = 1'b0;
		if (do_write) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = fsc_pkg::RESP_OKAY;
			unique case (st_ff.waddr)
				fsc_pkg::OFS_CONTROL: begin
					nxt_st.soft_pll = st_ff.wlane ? st_ff.wdat[fsc_pkg::CTL_PLL_BIT] : st_ff.soft_pll;
					nxt_st.freq = st_ff.wlane ? st_ff.wdat[fsc_pkg::CTL_FREQ_LSB +: 4] : st_ff.freq;
					nxt_st.scs = st_ff.wlane ? st_ff.wdat[1:0] : st_ff.scs;
					scs_change = st_ff.wlane && st_ff.wdat[1:0] != st_ff.scs;
				end
				fsc_pkg::OFS_TUNING: nxt_st.trim = st_ff.wlane ? st_ff.wdat[5:0] : st_ff.trim;
				fsc_pkg::OFS_FLAG: flag_clear = st_ff.wlane & st_ff.wdat[0];
				fsc_pkg::OFS_ENABLE: nxt_st.flag_en = st_ff.wlane ? st_ff.wdat[0] : st_ff.flag_en;
				fsc_pkg::OFS_STATUS: nxt_st.bresp = fsc_pkg::RESP_OKAY;
				default: begin
					nxt_st.bresp = fsc_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_ff.bvalid && i_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

		// Read channel
		rd_hit = 1'b1;
		unique case (i_araddr)
			fsc_pkg::OFS_CONTROL: rd_byte = {st_ff.soft_pll, st_ff.freq, 1'b0, st_ff.scs};
			fsc_pkg::OFS_STATUS: rd_byte = {st_ff.sync2[6] | ~i_secondary_osc_enable, st_ff.sync2[5],
				st_ff.cur == fsc_pkg::SRC_EXT, st_ff.sync2[4:0]};
			fsc_pkg::OFS_TUNING: rd_byte = {2'h0, st_ff.trim};
			fsc_pkg::OFS_FLAG: rd_byte = {7'h00, st_ff.flag};
			fsc_pkg::OFS_ENABLE: rd_byte = {7'h00, st_ff.flag_en};
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
		if (i_arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = {24'h000000, rd_byte};
			nxt_st.rresp = rd_hit ? fsc_pkg::RESP_OKAY : fsc_pkg::RESP_SLVERR;
		end else if (st_ff.rvalid && i_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.arready = !nxt_st.rvalid;

		// Start-up timer: crystal oscillations only
		if (!crystal) begin
			nxt_st.ost_done = !i_sleep;
		end else if (sleep_enter || i_sleep || wake || scs_change) begin
			nxt_st.ost_cnt = 11'h000;
			nxt_st.ost_done = 1'b0;
		end else if (!st_ff.ost_done && fall[0]) begin
			if (st_ff.ost_cnt == 11'(OST_COUNT - 1)) begin
				nxt_st.ost_done = 1'b1;
			end else begin
				nxt_st.ost_cnt = st_ff.ost_cnt + 11'h001;
			end
		end

		// Sample clock from the low oscillator, and the edge latch
		if (rise[3]) begin
			if (st_ff.div_cnt == 5'(HALF_COUNT - 1)) begin
				nxt_st.div_cnt = 5'h00;
				nxt_st.sample = !st_ff.sample;
			end else begin
				nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
			end
		end
		armed = i_config_failure_monitor_enable && !i_sleep && st_ff.ost_done && !st_ff.failsafe
			&& st_ff.scs == 2'h0 && i_cfg_fosc != fsc_pkg::FOSC_INTERNAL_OSCILLATOR;
		fail = 1'b0;
		if (nxt_st.sample != st_ff.sample) begin
			if (nxt_st.sample) begin
				nxt_st.latch = 1'b0;
			end else begin
				fail = armed && !st_ff.latch && !fall[0];
			end
		end
		if (fall[0]) begin
			nxt_st.latch = 1'b1;
		end

		// Fail-safe condition and failure flag
		if (sleep_enter || scs_change) begin
			nxt_st.failsafe = 1'b0;
		end else if (fail) begin
			nxt_st.failsafe = 1'b1;
		end
		if (fail) begin
			nxt_st.flag = 1'b1;
		end else if (flag_clear && !st_ff.failsafe) begin
			nxt_st.flag = 1'b0;
		end
		nxt_st.irq = nxt_st.flag & nxt_st.flag_en;

		// Wanted source
		if (i_sleep) begin
			target = fsc_pkg::SRC_NONE;
		end else if (st_ff.scs[1]) begin
			target = fsc_pkg::SRC_INT;
		end else if (st_ff.scs[0]) begin
			target = fsc_pkg::SRC_SOSC;
		end else if (i_cfg_fosc == fsc_pkg::FOSC_INTERNAL_OSCILLATOR || st_ff.failsafe) begin
			target = fsc_pkg::SRC_INT;
		end else if (!st_ff.ost_done) begin
			target = two_speed ? fsc_pkg::SRC_INT : fsc_pkg::SRC_NONE;
		end else begin
			target = fsc_pkg::SRC_EXT;
		end

		// Edge-aligned handover, shared by every kind of switch
		unique case (st_ff.sw)
			fsc_pkg::SW_IDLE: begin
				nxt_st.sysclk = fsc_pick(st_ff.cur, lvl, 1'b0);
				if (target != st_ff.cur) begin
					nxt_st.sw = fsc_pkg::SW_OLD;
					nxt_st.sw_tgt = target;
				end
			end
			fsc_pkg::SW_OLD: begin
				nxt_st.sysclk = fsc_pick(st_ff.cur, lvl, 1'b0);
				// A failed outgoing clock has no falling edge left to wait for
				if (fsc_pick(st_ff.cur, fall, 1'b1) || (st_ff.failsafe && st_ff.cur == fsc_pkg::SRC_EXT)) begin
					nxt_st.sysclk = 1'b0;
					nxt_st.sw = fsc_pkg::SW_NEW;
				end
			end
			fsc_pkg::SW_NEW: begin
				nxt_st.sysclk = 1'b0;
				if (fsc_pick(st_ff.sw_tgt, fall, 1'b1)) begin
					nxt_st.cur = st_ff.sw_tgt;
					nxt_st.sw = fsc_pkg::SW_IDLE;
				end
			end
		endcase

		nxt_st.switching = nxt_st.sw != fsc_pkg::SW_IDLE;
		nxt_st.pll_on = i_config_pll_enable | nxt_st.soft_pll;
		nxt_st.kind = fsc_decode(nxt_st.freq);
		nxt_st.pll_x4 = nxt_st.pll_on && nxt_st.freq == fsc_pkg::FREQ_PLL_CODE;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
			st_ff.freq <= fsc_pkg::FREQ_RESET;
			st_ff.scs <= fsc_pkg::SCS_RESET;
			st_ff.trim <= fsc_pkg::TRIM_RESET;
			st_ff.kind <= fsc_pkg::OSC_MF;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_awready = st_ff.awready;
	assign o_wready = st_ff.wready;
	assign o_bresp = st_ff.bresp;
	assign o_bvalid = st_ff.bvalid;
	assign o_arready = st_ff.arready;
	assign o_rdata = st_ff.rdata;
	assign o_rresp = st_ff.rresp;
	assign o_rvalid = st_ff.rvalid;
	assign o_sysclk = st_ff.sysclk;
	assign o_sysclk_src = st_ff.cur;
	assign o_switching = st_ff.switching;
	assign o_internal_freq_select = st_ff.freq;
	assign o_int_osc_kind = st_ff.kind;
	assign o_int_freq_pll = st_ff.pll_x4;
	assign o_pll_on = st_ff.pll_on;
	assign o_frequency_trim = st_ff.trim;
	assign o_osc_fail_irq = st_ff.irq;
endmodule

/* File: verification/fsc_monitor.sv */
`timescale 1ns/1ns
module fsc_monitor (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic i_rready,
	input wire logic i_config_pll_enable,
	input wire logic o_pll_on,
	input wire logic [3:0] o_internal_freq_select,
	input wire logic [1:0] o_int_osc_kind,
	input wire logic o_int_freq_pll,
	input wire logic [1:0] o_sysclk_src,
	input wire logic o_switching,
	input wire logic [5:0] o_frequency_trim
);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_rstn);
logic [1:0] kind_exp;
logic [3:0] fq;
assign fq = o_internal_freq_select;
always_comb begin
	if (fq[3:1] == 3'h0) begin
		kind_exp = 2'h0;
	end else if (fq == 4'h2 || fq[3:2] == 2'h1) begin
		kind_exp = 2'h1;
	end else begin
		kind_exp = 2'h2;
	end
end
chk_pll_forced: assert property ($past(i_rstn) && $past(i_config_pll_enable) |-> o_pll_on)
	else $error("pll off while forced on");
chk_osc_kind: assert property (o_int_osc_kind == kind_exp)
	else $error("oscillator kind does not match code");
chk_pll_code: assert property (o_int_freq_pll |-> fq == 4'he)
	else $error("pll rate on wrong code");
chk_src_handover: assert property ($changed(o_sysclk_src) |-> $past(o_switching))
	else $error("source changed without handover");
chk_field_write: assert property ($changed(o_frequency_trim) || $changed(fq) |-> $rose(o_bvalid))
	else $error("field changed without write");
chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
	else $error("write response dropped");
chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
	else $error("read data dropped");
chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
	else $error("read not answered");
chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
	else $error("write not answered");
endmodule
bind fsc_clock_select fsc_monitor mon_u (.*);

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
logic i_clk_sys = 1'h0, i_rstn = 1'h0, ext_run = 1'h1;
logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
logic [31:0] i_wdata = 32'h0, cyc = 32'h0;
logic [3:0] i_wstrb = 4'hf;
logic [2:0] i_cfg_fosc = 3'h5;
logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
logic i_ext_clk = 1'h0, i_sosc_clk = 1'h0, i_int_clk = 1'h0, i_lf_clk = 1'h0, i_sleep = 1'h0;
logic i_config_failure_monitor_enable = 1'h0, i_config_two_speed_enable = 1'h0;
logic i_config_pll_enable = 1'h0, i_secondary_osc_enable = 1'h0, i_secondary_osc_ready = 1'h0;
logic i_pll_ready = 1'h0, i_high_int_osc_ready = 1'h0, i_high_int_osc_locked = 1'h0;
logic i_high_int_osc_stable = 1'h0, i_medium_int_osc_ready = 1'h0, i_low_int_osc_ready = 1'h0;
logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sysclk, o_switching;
logic o_int_freq_pll, o_pll_on, o_osc_fail_irq;
logic [1:0] o_bresp, o_rresp, o_sysclk_src, o_int_osc_kind;
logic [31:0] o_rdata;
logic [3:0] o_internal_freq_select;
logic [5:0] o_frequency_trim;
int n_mismatch = 0;
int n_checks = 0;
localparam logic [7:0] A_CTL = fsc_pkg::OFS_CONTROL;
localparam logic [7:0] A_STA = fsc_pkg::OFS_STATUS;
localparam logic [7:0] A_TUN = fsc_pkg::OFS_TUNING;
localparam logic [7:0] A_FLG = fsc_pkg::OFS_FLAG;
localparam logic [7:0] A_ENA = fsc_pkg::OFS_ENABLE;
localparam logic [1:0] OK = fsc_pkg::RESP_OKAY;
localparam logic [1:0] ERR = fsc_pkg::RESP_SLVERR;
fsc_clock_select #(.OST_COUNT(8), .HALF_COUNT(2)) dut_u (.*);
always #4 i_clk_sys = ~i_clk_sys;
// ----
// Oscillator levels, each held at least one cycle
// ----
always @(posedge i_clk_sys) begin
	cyc <= cyc + 32'h1;
	if (ext_run) i_ext_clk <= ~i_ext_clk;
	if (cyc[1:0] == 2'h0) i_lf_clk <= ~i_lf_clk;
	i_int_clk <= cyc[1];
	i_sosc_clk <= cyc[2];
	if (cyc == 32'h4e20) begin
		n_mismatch++;
		final_report();
	end
end
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	n_checks++;
	if (g !== e) begin
		n_mismatch++;
		$display("Error %0t: got %h expected %h", $time, g, e);
	end
endtask
task automatic tick(input int n);
	repeat (n) @(posedge i_clk_sys);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
	int t;
	t = 0;
	i_awaddr <= a;
	i_wdata <= {24'h0, d};
	i_awvalid <= 1'h1;
	i_wvalid <= 1'h1;
	i_bready <= 1'h1;
	do begin
		@(posedge i_clk_sys);
		t++;
		if (i_awvalid && o_awready) i_awvalid <= 1'h0;
		if (i_wvalid && o_wready) i_wvalid <= 1'h0;
	end while (!o_bvalid && t < 50);
	i_bready <= 1'h0;
	chk(o_bresp, er);
	@(posedge i_clk_sys);
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
	int t;
	t = 0;
	i_araddr <= a;
	i_arvalid <= 1'h1;
	i_rready <= 1'h1;
	do begin
		@(posedge i_clk_sys);
		t++;
		if (i_arvalid && o_arready) i_arvalid <= 1'h0;
	end while (!o_rvalid && t < 50);
	i_rready <= 1'h0;
	chk(o_rdata, {24'h0, e});
	chk(o_rresp, er);
	@(posedge i_clk_sys);
endtask
task automatic wait_src(input logic [1:0] s);
	int t;
	t = 0;
	while (o_sysclk_src !== s && t < 200) begin
		@(posedge i_clk_sys);
		t++;
	end
	chk(o_sysclk_src, s);
endtask
task automatic t_reset;
	rd(A_CTL, 8'h38, OK);
	rd(A_TUN, 8'h00, OK);
	rd(A_FLG, 8'h00, OK);
	chk(o_internal_freq_select, fsc_pkg::FREQ_RESET);
endtask
task automatic t_regs;
	logic [1:0] k;
	i_config_pll_enable <= 1'h1;
	tick(2);
	chk(o_pll_on, 1'h1);
	i_config_pll_enable <= 1'h0;
	wr(A_CTL, 8'h72, OK);
	tick(2);
	chk(o_pll_on, 1'h0);
	chk(o_int_freq_pll, 1'h0);
	wr(A_CTL, 8'hf2, OK);
	tick(2);
	chk(o_int_freq_pll, 1'h1);
	for (int c = 0; c < 16; c++) begin
		wr(A_CTL, {1'h0, c[3:0], 3'h2}, OK);
		tick(2);
		k = (c < 2) ? 2'h0 : ((c == 2 || c[3:2] == 2'h1) ? 2'h1 : 2'h2);
		chk(o_int_osc_kind, k);
		chk(o_internal_freq_select, c[3:0]);
	end
	wr(A_CTL, 8'h7f, OK);
	rd(A_CTL, 8'h7b, OK);
	wr(A_TUN, 8'hff, OK);
	rd(A_TUN, 8'h3f, OK);
	chk(o_frequency_trim, 6'h3f);
	wr(8'h14, 8'h55, ERR);
	rd(8'h14, 8'h00, ERR);
	wr(A_STA, 8'h00, OK);
endtask
task automatic t_status;
	i_pll_ready <= 1'h1;
	i_high_int_osc_locked <= 1'h1;
	i_low_int_osc_ready <= 1'h1;
	tick(3);
	rd(A_STA, 8'hca, OK);
	i_secondary_osc_enable <= 1'h1;
	i_high_int_osc_ready <= 1'h1;
	i_high_int_osc_stable <= 1'h1;
	i_medium_int_osc_ready <= 1'h1;
	tick(3);
	rd(A_STA, 8'h5f, OK);
	i_high_int_osc_ready <= 1'h0;
	i_high_int_osc_stable <= 1'h0;
	i_medium_int_osc_ready <= 1'h0;
endtask
task automatic t_fail;
	i_config_failure_monitor_enable <= 1'h1;
	wr(A_CTL, 8'h38, OK);
	wait_src(2'h1);
	tick(3);
	rd(A_STA, 8'h6a, OK);
	wr(A_ENA, 8'h01, OK);
	ext_run <= 1'h0;
	wait_src(2'h3);
	rd(A_FLG, 8'h01, OK);
	chk(o_osc_fail_irq, 1'h1);
	wr(A_FLG, 8'h01, OK);
	rd(A_FLG, 8'h01, OK);
	wr(A_ENA, 8'h00, OK);
	tick(2);
	chk(o_osc_fail_irq, 1'h0);
	wr(A_ENA, 8'h01, OK);
	ext_run <= 1'h1;
	tick(40);
	chk(o_sysclk_src, 2'h3);
	i_cfg_fosc <= 3'h0;
	i_config_two_speed_enable <= 1'h1;
	wr(A_CTL, 8'h3a, OK);
	wr(A_FLG, 8'h01, OK);
	rd(A_FLG, 8'h00, OK);
	chk(o_osc_fail_irq, 1'h0);
	wr(A_CTL, 8'h38, OK);
	chk(o_sysclk_src, 2'h3);
	wait_src(2'h1);
	tick(2);
	chk(o_sysclk, !i_ext_clk);
endtask
task automatic final_report;
	if (n_mismatch == 0 && n_checks > 0) begin
		$display("Run complete: PASS");
	end else begin
		$display("Run complete: FAIL");
	end
	$finish;
endtask
initial begin
	tick(4);
	i_rstn <= 1'h1;
	tick(1);
	t_reset();
	t_regs();
	t_status();
	t_fail();
	final_report();
end
endmodule
